/* design/ocrs_top.sv */
`timescale 1ns/1ps
`include "ocrs_regs.svh"
module ocrs_top (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire logic                 ce,
  // Register port
  input  wire logic                 reg_cs,
  input  wire logic                 reg_wr,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  output logic      [7:0]           reg_rdata,
  // Sync references and output timing
  input  wire logic                 ref8k_main,
  input  wire logic                 ref2k_main,
  input  wire logic                 ref8k_aux,
  input  wire logic                 ref2k_aux,
  input  wire logic                 cmos_period_tick,
  input  wire logic                 diff_period_tick,
  // Loop status
  input  wire logic                 ref_selected,
  input  wire logic                 lock_achieved,
  input  wire logic                 phase_loss,
  input  wire logic                 ref_disqualified,
  input  wire logic                 standby_ok,
  input  wire logic                 prelock_timeout,
  // Output routing
  output ocrs_pkg::ocrs_src_e       cmos_src,
  output ocrs_pkg::ocrs_div_t       cmos_div,
  output logic                      cmos_tap_ok,
  output ocrs_pkg::ocrs_src_e       diff_src,
  output ocrs_pkg::ocrs_div_t       diff_div,
  output logic                      diff_tap_ok,
  // Rates
  output ocrs_pkg::ocrs_khz_t       fixed_a_khz,
  output ocrs_pkg::ocrs_khz_t       fixed_b_khz,
  output ocrs_pkg::ocrs_khz_t       pll_a_khz,
  output logic                      pll_a_analog_fb,
  output logic                      main_rate_bad,
  output ocrs_pkg::ocrs_khz_t       aux_fwd_khz,
  output logic                      aux_squelch,
  output logic                      pll_b_from_main,
  output ocrs_pkg::ocrs_khz_t       pll_b_khz,
  // Oscillator trim
  output logic      [15:0]          osc_trim,
  output logic      [16:0]          osc_trim_offset,
  // Sync outputs
  output logic                      frame_sync_out,
  output logic                      multiframe_sync_out,
  output logic                      cmos_lowrate_out,
  output logic                      diff_lowrate_out,
  // Operating state
  output ocrs_pkg::ocrs_state_e     op_state,
  output logic                      free_run,
  output logic                      forced_mode
);

  ////////////////////////////////////////////////////////////////////////
  // Register storage
  logic [7:0] family_r, fixsel_r, trim_lo_r, trim_hi_r;
  logic [7:0] cmos_r, diff_r, sync_en_r, aux_r, main_r, style_r, force_r;
  logic [7:0] rdata_nxt;
  logic       wr_en;

  assign wr_en = reg_cs & reg_wr;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      family_r  <= `OCRS_RST_ZERO;
      fixsel_r  <= `OCRS_RST_ZERO;
      trim_lo_r <= `OCRS_TRIM_ZERO_LO;
      trim_hi_r <= `OCRS_TRIM_ZERO_HI;
      cmos_r    <= `OCRS_RST_ZERO;
      diff_r    <= `OCRS_RST_ZERO;
      sync_en_r <= `OCRS_RST_SYNC_EN;
      aux_r     <= `OCRS_RST_ZERO;
      main_r    <= `OCRS_RST_MAIN;
      style_r   <= `OCRS_RST_ZERO;
      force_r   <= `OCRS_RST_ZERO;
    end else if (ce && wr_en) begin
      case (reg_addr)
        `OCRS_A_FAMILY:  family_r  <= reg_wdata;
        `OCRS_A_FIXSEL:  fixsel_r  <= reg_wdata;
        `OCRS_A_TRIM_LO: trim_lo_r <= reg_wdata;
        `OCRS_A_TRIM_HI: trim_hi_r <= reg_wdata;
        `OCRS_A_CMOS:    cmos_r    <= reg_wdata;
        `OCRS_A_DIFF:    diff_r    <= reg_wdata;
        `OCRS_A_SYNC_EN: sync_en_r <= reg_wdata;
        `OCRS_A_AUX:     aux_r     <= reg_wdata;
        `OCRS_A_MAIN:    main_r    <= reg_wdata;
        `OCRS_A_STYLE:   style_r   <= reg_wdata;
        `OCRS_A_FORCE:   force_r   <= reg_wdata;
        default: ;
      endcase
    end
  end

  always_comb begin
    case (reg_addr)
      `OCRS_A_FAMILY:  rdata_nxt = family_r;
      `OCRS_A_FIXSEL:  rdata_nxt = fixsel_r;
      `OCRS_A_TRIM_LO: rdata_nxt = trim_lo_r;
      `OCRS_A_TRIM_HI: rdata_nxt = trim_hi_r;
      `OCRS_A_CMOS:    rdata_nxt = cmos_r;
      `OCRS_A_DIFF:    rdata_nxt = diff_r;
      `OCRS_A_SYNC_EN: rdata_nxt = sync_en_r;
      `OCRS_A_AUX:     rdata_nxt = aux_r;
      `OCRS_A_MAIN:    rdata_nxt = main_r;
      `OCRS_A_STYLE:   rdata_nxt = style_r;
      `OCRS_A_FORCE:   rdata_nxt = force_r;
      `OCRS_A_OPSTATE: rdata_nxt = {5'h00, op_state};
      default:         rdata_nxt = 8'h00;
    endcase
  end

  // Read data lands one cycle after the strobe
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) reg_rdata <= 8'h00;
    else if (ce && reg_cs && !reg_wr) reg_rdata <= rdata_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // Oscillator trim
  logic [15:0] trim_w;
  assign trim_w = {trim_hi_r, trim_lo_r};

  // Offset in trim steps against the zero-ppm point
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      osc_trim        <= `OCRS_TRIM_ZERO;
      osc_trim_offset <= 17'h00000;
    end else if (ce) begin
      osc_trim        <= trim_w;
      osc_trim_offset <= {1'b0, trim_w} - {1'b0, `OCRS_TRIM_ZERO};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Rate decode
  ocrs_pkg::ocrs_khz_t fix_a_nxt, fix_b_nxt, pa_nxt, aux_nxt, synth_b, pb_nxt;
  logic                pa_bad;

  function automatic ocrs_pkg::ocrs_khz_t fixed_rate(input logic fam, input logic [1:0] code);
    fixed_rate = (fam ? `OCRS_KHZ_T1_BASE : `OCRS_KHZ_E1_BASE) << code;
  endfunction : fixed_rate

  assign fix_a_nxt = fixed_rate(family_r[`OCRS_F_FAM_A], fixsel_r[`OCRS_F_SEL_A]);
  assign fix_b_nxt = fixed_rate(family_r[`OCRS_F_FAM_B], fixsel_r[`OCRS_F_SEL_B]);

  always_comb begin
    pa_bad = 1'b0;
    case (main_r[`OCRS_F_RATE])
      3'b000, 3'b001: pa_nxt = `OCRS_KHZ_OC;
      3'b010:         pa_nxt = `OCRS_KHZ_E1_X12_MODE;
      3'b011:         pa_nxt = `OCRS_KHZ_E1_X16_MODE;
      3'b100:         pa_nxt = `OCRS_KHZ_T1_X24_MODE;
      3'b101:         pa_nxt = `OCRS_KHZ_T1_X16_MODE;
      default: begin
        pa_nxt = 19'd0;
        pa_bad = 1'b1;
      end
    endcase
  end

  always_comb begin
    case (aux_r[`OCRS_F_RATE])
      3'b000, 3'b001: aux_nxt = `OCRS_KHZ_AUX_OC;
      3'b010:         aux_nxt = `OCRS_KHZ_AUX_E1_X12_MODE;
      3'b011:         aux_nxt = `OCRS_KHZ_AUX_E1_X16_MODE;
      3'b100:         aux_nxt = `OCRS_KHZ_AUX_24T1;
      3'b101:         aux_nxt = `OCRS_KHZ_AUX_16T1;
      3'b110:         aux_nxt = `OCRS_KHZ_AUX_E3;
      default:        aux_nxt = `OCRS_KHZ_AUX_DS3;
    endcase
  end

  always_comb begin
    case (main_r[`OCRS_F_B_SYNTH])
      2'b00:   synth_b = `OCRS_KHZ_E1_X12_MODE;
      2'b01:   synth_b = `OCRS_KHZ_E1_X16_MODE;
      2'b10:   synth_b = `OCRS_KHZ_T1_X24_MODE;
      default: synth_b = `OCRS_KHZ_T1_X16_MODE;
    endcase
  end

  // Aux code is ignored once loop B takes synthesis
  assign pb_nxt = main_r[`OCRS_F_B_SRC] ? synth_b : (aux_nxt << 2);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fixed_a_khz     <= 19'd0;
      fixed_b_khz     <= 19'd0;
      pll_a_khz       <= 19'd0;
      pll_a_analog_fb <= 1'b0;
      main_rate_bad   <= 1'b0;
      aux_fwd_khz     <= 19'd0;
      aux_squelch     <= 1'b0;
      pll_b_from_main <= 1'b0;
      pll_b_khz       <= 19'd0;
    end else if (ce) begin
      fixed_a_khz     <= fix_a_nxt;
      fixed_b_khz     <= fix_b_nxt;
      pll_a_khz       <= pa_nxt;
      pll_a_analog_fb <= main_r[`OCRS_F_RATE] == 3'b001;
      main_rate_bad   <= pa_bad;
      aux_fwd_khz     <= main_r[`OCRS_F_B_SRC] ? 19'd0 : aux_nxt;
      aux_squelch     <= !main_r[`OCRS_F_B_SRC] && aux_r[`OCRS_F_RATE] == 3'b000;
      pll_b_from_main <= main_r[`OCRS_F_B_SRC];
      pll_b_khz       <= pb_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output selection, applied on cycle boundaries
  logic [3:0] cmos_eff_r, diff_eff_r;
  logic       no_612_b;

  // An idle output has no cycles, so a change from off applies at once
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmos_eff_r <= 4'h0;
      diff_eff_r <= 4'h0;
    end else if (ce) begin
      if (cmos_period_tick || cmos_eff_r == 4'h0) cmos_eff_r <= cmos_r[`OCRS_F_CMOS];
      if (diff_period_tick || diff_eff_r == 4'h0) diff_eff_r <= diff_r[`OCRS_F_DIFF];
    end
  end

  assign no_612_b = !main_r[`OCRS_F_B_SRC] && aux_r[2:1] == 2'b11;

  ocrs_sel_if cmos_sel ();
  ocrs_sel_if diff_sel ();

  ocrs_out_decode #(.DIFF(1'b0)) u_cmos_dec (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .ce       (ce),
    .code     (cmos_eff_r),
    .no_612_a (1'b0),
    .no_612_b (no_612_b),
    .sel      (cmos_sel.dec)
  );

  ocrs_out_decode #(.DIFF(1'b1)) u_diff_dec (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .ce       (ce),
    .code     (diff_eff_r),
    .no_612_a (1'b0),
    .no_612_b (no_612_b),
    .sel      (diff_sel.dec)
  );

  assign cmos_src    = cmos_sel.src;
  assign cmos_div    = cmos_sel.div;
  assign cmos_tap_ok = cmos_sel.tap_ok;
  assign diff_src    = diff_sel.src;
  assign diff_div    = diff_sel.div;
  assign diff_tap_ok = diff_sel.tap_ok;

  ////////////////////////////////////////////////////////////////////////
  // Sync shaping; pulse width is timed by the single-ended output
  logic ref8k_sel, ref2k_sel, low8k, low2k;

  assign ref8k_sel = style_r[`OCRS_F_SYNC_AUX] ? ref8k_aux : ref8k_main;
  assign ref2k_sel = style_r[`OCRS_F_SYNC_AUX] ? ref2k_aux : ref2k_main;

  ocrs_sync_shaper u_frame (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .ce          (ce),
    .ref_in      (ref8k_main),
    .period_tick (cmos_period_tick),
    .style       (style_r[`OCRS_F_STY_8K]),
    .enable      (sync_en_r[`OCRS_F_EN_FRAME]),
    .sync_out    (frame_sync_out)
  );

  ocrs_sync_shaper u_mframe (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .ce          (ce),
    .ref_in      (ref2k_main),
    .period_tick (cmos_period_tick),
    .style       (style_r[`OCRS_F_STY_2K]),
    .enable      (sync_en_r[`OCRS_F_EN_MFRAME]),
    .sync_out    (multiframe_sync_out)
  );

  ocrs_sync_shaper u_low8k (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .ce          (ce),
    .ref_in      (ref8k_sel),
    .period_tick (cmos_period_tick),
    .style       (style_r[`OCRS_F_STY_8K]),
    .enable      (1'b1),
    .sync_out    (low8k)
  );

  ocrs_sync_shaper u_low2k (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .ce          (ce),
    .ref_in      (ref2k_sel),
    .period_tick (cmos_period_tick),
    .style       (style_r[`OCRS_F_STY_2K]),
    .enable      (1'b1),
    .sync_out    (low2k)
  );

  // Only the 2k/8k codes carry the shaped low-rate signal
  assign cmos_lowrate_out = (cmos_sel.src == ocrs_pkg::src_8k) ? low8k :
                            (cmos_sel.src == ocrs_pkg::src_2k) ? low2k : 1'b0;
  assign diff_lowrate_out = (diff_sel.src == ocrs_pkg::src_8k) ? low8k :
                            (diff_sel.src == ocrs_pkg::src_2k) ? low2k : 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // Operating state machine
  ocrs_pkg::ocrs_state_e state_r, state_nxt, force_st;

  always_comb begin
    case (force_r[`OCRS_F_FORCE_ST])
      3'd1:    force_st = ocrs_pkg::st_pre_locked;
      3'd2:    force_st = ocrs_pkg::st_locked;
      3'd3:    force_st = ocrs_pkg::st_phase_lost;
      3'd4:    force_st = ocrs_pkg::st_holdover;
      3'd5:    force_st = ocrs_pkg::st_pre_locked2;
      default: force_st = ocrs_pkg::st_free_run;
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ocrs_pkg::st_free_run:
        if (ref_selected) state_nxt = ocrs_pkg::st_pre_locked;
      ocrs_pkg::st_pre_locked:
        if (lock_achieved) state_nxt = ocrs_pkg::st_locked;
        else if (prelock_timeout) state_nxt = ocrs_pkg::st_free_run;
      ocrs_pkg::st_locked:
        if (ref_disqualified) state_nxt = standby_ok ? ocrs_pkg::st_pre_locked2 : ocrs_pkg::st_holdover;
        else if (phase_loss) state_nxt = ocrs_pkg::st_phase_lost;
      ocrs_pkg::st_phase_lost:
        if (ref_disqualified) state_nxt = standby_ok ? ocrs_pkg::st_pre_locked2 : ocrs_pkg::st_holdover;
        else if (lock_achieved) state_nxt = ocrs_pkg::st_locked;
      ocrs_pkg::st_holdover:
        if (ref_selected) state_nxt = ocrs_pkg::st_pre_locked2;
      ocrs_pkg::st_pre_locked2:
        if (lock_achieved) state_nxt = ocrs_pkg::st_locked;
        else if (prelock_timeout) state_nxt = ocrs_pkg::st_holdover;
      default: state_nxt = ocrs_pkg::st_free_run;
    endcase
    if (force_r[`OCRS_F_FORCE_EN]) state_nxt = force_st;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) state_r <= ocrs_pkg::st_free_run;
    else if (ce) state_r <= state_nxt;
  end

  assign op_state    = state_r;
  assign free_run    = state_r == ocrs_pkg::st_free_run;
  assign forced_mode = force_r[`OCRS_F_FORCE_EN];
endmodule : ocrs_top

/* include/ocrs_regs.svh */
`ifndef OCRS_REGS_SVH
`define OCRS_REGS_SVH
`define OCRS_A_FAMILY     8'h38
`define OCRS_A_FIXSEL     8'h39
`define OCRS_A_TRIM_LO    8'h3c
`define OCRS_A_TRIM_HI    8'h3d
`define OCRS_A_CMOS       8'h61
`define OCRS_A_DIFF       8'h62
`define OCRS_A_SYNC_EN    8'h63
`define OCRS_A_AUX        8'h64
`define OCRS_A_MAIN       8'h65
`define OCRS_A_STYLE      8'h7a
`define OCRS_A_OPSTATE    8'h09
`define OCRS_A_FORCE      8'h4d
`define OCRS_F_FAM_A      5
`define OCRS_F_FAM_B      6
`define OCRS_F_SEL_A      5:4
`define OCRS_F_SEL_B      7:6
`define OCRS_F_CMOS       3:0
`define OCRS_F_DIFF       7:4
`define OCRS_F_EN_FRAME   7
`define OCRS_F_EN_MFRAME  6
`define OCRS_F_RATE       2:0
`define OCRS_F_B_SRC      6
`define OCRS_F_B_SYNTH    5:4
`define OCRS_F_SYNC_AUX   7
`define OCRS_F_STY_8K     3:2
`define OCRS_F_STY_2K     1:0
`define OCRS_F_FORCE_EN   3
`define OCRS_F_FORCE_ST   2:0
`define OCRS_RST_ZERO     8'h00
`define OCRS_RST_SYNC_EN  8'hc0
`define OCRS_RST_MAIN     8'h01
`define OCRS_TRIM_ZERO    16'h9999
`define OCRS_TRIM_ZERO_LO 8'h99
`define OCRS_TRIM_ZERO_HI 8'h99
`define OCRS_KHZ_E1_BASE  19'd2048
`define OCRS_KHZ_T1_BASE  19'd1544
`define OCRS_KHZ_OC       19'd311040
`define OCRS_KHZ_E1_X12_MODE     19'd98304
`define OCRS_KHZ_E1_X16_MODE     19'd131072
`define OCRS_KHZ_T1_X24_MODE    19'd148224
`define OCRS_KHZ_T1_X16_MODE    19'd98816
`define OCRS_KHZ_AUX_OC   19'd77760
`define OCRS_KHZ_AUX_E1_X12_MODE 19'd24576
`define OCRS_KHZ_AUX_E1_X16_MODE 19'd32768
`define OCRS_KHZ_AUX_24T1 19'd37056
`define OCRS_KHZ_AUX_16T1 19'd24704
`define OCRS_KHZ_AUX_E3   19'd68736
`define OCRS_KHZ_AUX_DS3  19'd44736
`endif

/* include/ocrs_pkg.sv */
package ocrs_pkg;
  typedef enum logic [2:0] {
    src_off, src_2k, src_8k, src_fixed_a, src_fixed_b, src_pll_a, src_pll_b
  } ocrs_src_e;
  typedef enum logic [2:0] {
    st_free_run, st_pre_locked, st_locked, st_phase_lost, st_holdover, st_pre_locked2
  } ocrs_state_e;
  typedef logic [18:0] ocrs_khz_t;
  typedef logic [6:0]  ocrs_div_t;
endpackage : ocrs_pkg

/* include/ocrs_sel_if.sv */
`timescale 1ns/1ps
interface ocrs_sel_if;
  ocrs_pkg::ocrs_src_e src;
  ocrs_pkg::ocrs_div_t div;
  logic                tap_ok;
  modport dec (output src, output div, output tap_ok);
  modport top (input src, input div, input tap_ok);
endinterface : ocrs_sel_if

/* design/ocrs_out_decode.sv */
`timescale 1ns/1ps
`include "ocrs_regs.svh"
module ocrs_out_decode #(
  parameter bit DIFF = 1'b0
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // Selection
  input  wire logic [3:0] code,
  input  wire logic       no_612_a,
  input  wire logic       no_612_b,
  // Decoded source
  ocrs_sel_if.dec         sel
);
  ocrs_pkg::ocrs_src_e src_nxt;
  ocrs_pkg::ocrs_div_t div_nxt;
  logic                bad_tap;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    src_nxt = ocrs_pkg::src_pll_a;
    div_nxt = 7'd1;
    case (code)
      4'h0: src_nxt = ocrs_pkg::src_off;
      4'h1: src_nxt = ocrs_pkg::src_2k;
      4'h2: src_nxt = ocrs_pkg::src_8k;
      4'h3: begin
        if (DIFF) div_nxt = 7'd2;
        else src_nxt = ocrs_pkg::src_fixed_b;
      end
      4'h4: src_nxt = ocrs_pkg::src_fixed_a;
      4'h5: div_nxt = DIFF ? 7'd1 : 7'd48;
      4'h6: div_nxt = 7'd16;
      4'h7: div_nxt = 7'd12;
      4'h8: div_nxt = 7'd8;
      4'h9: div_nxt = 7'd6;
      4'ha: div_nxt = 7'd4;
      4'hb: begin src_nxt = ocrs_pkg::src_pll_b; div_nxt = 7'd64; end
      4'hc: begin src_nxt = ocrs_pkg::src_pll_b; div_nxt = 7'd48; end
      4'hd: begin src_nxt = ocrs_pkg::src_pll_b; div_nxt = 7'd16; end
      4'he: begin src_nxt = ocrs_pkg::src_pll_b; div_nxt = 7'd8; end
      default: begin src_nxt = ocrs_pkg::src_pll_b; div_nxt = 7'd4; end
    endcase
  end

  // E3 and DS3 loop rates have no divide-by-6 or -12 tap
  assign bad_tap = (div_nxt == 7'd6 || div_nxt == 7'd12) &&
                   ((src_nxt == ocrs_pkg::src_pll_a && no_612_a) ||
                    (src_nxt == ocrs_pkg::src_pll_b && no_612_b));

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sel.src    <= ocrs_pkg::src_off;
      sel.div    <= 7'd1;
      sel.tap_ok <= 1'b0;
    end else if (ce) begin
      sel.src    <= bad_tap ? ocrs_pkg::src_off : src_nxt;
      sel.div    <= div_nxt;
      sel.tap_ok <= ~bad_tap && (src_nxt != ocrs_pkg::src_off);
    end
  end
endmodule : ocrs_out_decode

/* design/ocrs_sync_shaper.sv */
`timescale 1ns/1ps
module ocrs_sync_shaper (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // Reference and timing
  input  wire logic       ref_in,
  input  wire logic       period_tick,
  // Control
  input  wire logic [1:0] style,
  input  wire logic       enable,
  // Output
  output logic            sync_out
);
  logic ref_d_r;
  logic armed_r;
  logic pulse_r;
  logic rise;

  assign rise = ref_in & ~ref_d_r;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) ref_d_r <= 1'b0;
    else if (ce) ref_d_r <= ref_in;
  end

  // Pulse spans one output period, tick to tick
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      armed_r <= 1'b0;
      pulse_r <= 1'b0;
    end else if (ce) begin
      if (rise) armed_r <= 1'b1;
      else if (period_tick) armed_r <= 1'b0;
      if (period_tick) pulse_r <= armed_r;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) sync_out <= 1'b0;
    else if (ce) sync_out <= enable & ((style[0] ? pulse_r : ref_d_r) ^ style[1]);
  end
endmodule : ocrs_sync_shaper

/* sim/ocrs_top_assertions.sv */
`timescale 1ns/1ps
module ocrs_chk (
  // Clock and reset
  input logic                  clk_sys,
  input logic                  rst_n,
  input logic                  ce,
  // Loop status and state
  input logic                  ref_selected,
  input logic                  lock_achieved,
  input ocrs_pkg::ocrs_state_e op_state,
  input logic                  free_run,
  input logic                  forced_mode,
  // Rates
  input logic                  main_rate_bad,
  input ocrs_pkg::ocrs_khz_t   pll_a_khz,
  input logic                  pll_b_from_main,
  input ocrs_pkg::ocrs_khz_t   aux_fwd_khz,
  input logic                  aux_squelch,
  // Routing and trim
  input ocrs_pkg::ocrs_src_e   cmos_src,
  input logic                  cmos_tap_ok,
  input logic                  cmos_lowrate_out,
  input logic [15:0]           osc_trim,
  input logic [16:0]           osc_trim_offset
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  // Stable trim first, so a one-cycle lag of the offset is tolerated
  a_trim_zero: assert property (ce && $stable(osc_trim) |->
    osc_trim_offset == {1'b0, osc_trim} - 17'h09999) else $error("trim offset wrong");
  a_free_flag: assert property (free_run == (op_state == ocrs_pkg::st_free_run))
    else $error("free run flag wrong");
  a_bad_main: assert property (main_rate_bad |-> pll_a_khz == 19'h0)
    else $error("forbidden main code gives a rate");
  a_aux_mute: assert property (pll_b_from_main |-> aux_fwd_khz == 19'h0 && !aux_squelch)
    else $error("aux rate used while loop b fed from main");
  a_low_idle: assert property (!(cmos_src inside {ocrs_pkg::src_2k, ocrs_pkg::src_8k}) |->
    !cmos_lowrate_out) else $error("low rate output active without selection");
  a_off_tap: assert property (cmos_src == ocrs_pkg::src_off |-> !cmos_tap_ok)
    else $error("tap ok on idle output");
  a_sel_exit: assert property (ce && !forced_mode && op_state == ocrs_pkg::st_free_run &&
    ref_selected |=> op_state == ocrs_pkg::st_pre_locked) else $error("no exit from free run");
  a_lock_gain: assert property (ce && !forced_mode && op_state == ocrs_pkg::st_pre_locked &&
    lock_achieved |=> op_state == ocrs_pkg::st_locked) else $error("lock not entered");
endmodule : ocrs_chk

bind ocrs_top ocrs_chk u_ocrs_chk (.*);

/* sim/tb.sv */
`timescale 1ns/1ps
module tb;
  logic clk_sys, rst_n, ce, reg_cs, reg_wr, ref8k_main, ref2k_main, ref8k_aux, ref2k_aux;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic cmos_period_tick, diff_period_tick, cmos_tap_ok, diff_tap_ok, pll_a_analog_fb, main_rate_bad;
  logic ref_selected, lock_achieved, phase_loss, ref_disqualified, standby_ok, prelock_timeout;
  logic aux_squelch, pll_b_from_main, frame_sync_out, multiframe_sync_out, free_run, forced_mode;
  logic cmos_lowrate_out, diff_lowrate_out;
  logic [15:0] osc_trim;
  logic [16:0] osc_trim_offset;
  ocrs_pkg::ocrs_src_e cmos_src, diff_src;
  ocrs_pkg::ocrs_div_t cmos_div, diff_div;
  ocrs_pkg::ocrs_khz_t fixed_a_khz, fixed_b_khz, pll_a_khz, aux_fwd_khz, pll_b_khz;
  ocrs_pkg::ocrs_state_e op_state;
  int error_cnt, checked, seed = 53;
  logic [31:0] d;
  logic [3:0] p1, p2;
  logic [2:0] m;
  ocrs_pkg::ocrs_khz_t mk [8] = '{311040, 311040, 98304, 131072, 148224, 98816, 0, 0};
  ocrs_pkg::ocrs_khz_t ak [8] = '{77760, 77760, 24576, 32768, 37056, 24704, 68736, 44736};
  ocrs_pkg::ocrs_khz_t bk [8] = '{311040, 311040, 98304, 131072, 148224, 98816, 274944, 178944};
  logic [7:0] ra [12] = '{8'h38, 8'h39, 8'h3c, 8'h3d, 8'h61, 8'h62, 8'h63, 8'h64, 8'h65, 8'h7a, 8'h4d, 8'h40};
  logic [7:0] rv [12] = '{0, 0, 8'h99, 8'h99, 0, 0, 8'hc0, 0, 1, 0, 0, 0};
  logic [5:0] sv [11] = '{6'h20, 6'h01, 6'h20, 6'h10, 6'h08, 6'h10, 6'h06, 6'h01, 6'h20, 6'h10, 6'h04};
  logic [2:0] se [11] = '{1, 0, 1, 2, 3, 2, 5, 4, 5, 2, 4};

  ocrs_top u_ocrs_top (.*);

  initial begin
    clk_sys = 0;
    forever #20 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////
  task automatic chk(string n, logic [18:0] s, logic [18:0] e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic acc(logic w, logic [7:0] a, logic [7:0] v);
    @(posedge clk_sys) #1 {reg_cs, reg_wr, reg_addr, reg_wdata} = {1'b1, w, a, v};
    @(posedge clk_sys) #1 reg_cs = 0;
  endtask : acc
  task automatic settle;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : settle
  // Codes only reload on a period tick once a nonzero code is running
  task automatic tick;
    @(posedge clk_sys) #1 {cmos_period_tick, diff_period_tick} = 2'h3;
    @(posedge clk_sys) #1 {cmos_period_tick, diff_period_tick} = 2'h0;
    settle;
  endtask : tick
  task automatic st(logic [5:0] v);
    {ref_selected, lock_achieved, phase_loss, ref_disqualified, standby_ok, prelock_timeout} = v;
  endtask : st
  task automatic give_verdict;
    $display("Checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  function automatic ocrs_pkg::ocrs_khz_t fx(logic f, logic [1:0] s);
    return (f ? 19'd1544 : 19'd2048) << s;
  endfunction : fx
  // Returns {source, tap}; tap only meaningful for loop sources
  function automatic logic [9:0] oexp(logic [3:0] c, bit df);
    logic [6:0] t [16] = '{0, 0, 0, 2, 0, 48, 16, 12, 8, 6, 4, 64, 48, 16, 8, 4};
    logic [2:0] s;
    s = c > 10 ? ocrs_pkg::src_pll_b : c > 4 ? ocrs_pkg::src_pll_a : c == 4 ? ocrs_pkg::src_fixed_a :
        c == 3 ? (df ? ocrs_pkg::src_pll_a : ocrs_pkg::src_fixed_b) : c[2:0];
    return {s, (df && c == 5) ? 7'h01 : t[c]};
  endfunction : oexp
  ////////////////////////////////////////
  initial begin
    {rst_n, reg_cs, reg_wr, reg_addr, reg_wdata, ref8k_main, ref2k_main, ref8k_aux, ref2k_aux} = '0;
    {cmos_period_tick, diff_period_tick, p1, p2} = '0;
    ce = 1;
    st(0);
    repeat (10) @(posedge clk_sys);
    #1 rst_n = 1;
    chk("state", op_state, 0);
    chk("trim", osc_trim, 16'h9999);
    chk("free", free_run, 1);
    foreach (ra[i]) begin
      acc(0, ra[i], 0);
      chk("rdata", reg_rdata, rv[i]);
    end
    for (int i = 0; i < 4; i++) begin
      d = i == 0 ? 0 : i == 1 ? 32'hffff : $random(seed);
      acc(1, 8'h3c, d[7:0]);
      acc(1, 8'h3d, d[15:8]);
      settle;
      chk("trim", osc_trim, d[15:0]);
      chk("offset", osc_trim_offset, 17'({1'b0, d[15:0]} - 17'h09999));
    end
    for (int i = 0; i < 16; i++) begin
      acc(1, 8'h38, {1'b0, i[3], i[0], 5'h0});
      acc(1, 8'h39, {~i[2:1], i[2:1], 4'h0});
      settle;
      chk("fix_a", fixed_a_khz, fx(i[0], i[2:1]));
      chk("fix_b", fixed_b_khz, fx(i[3], ~i[2:1]));
    end
    // Synthesis to both loops uses one setting, as software must keep it
    for (int i = 0; i < 16; i++) begin
      m = i[3] ? 3'(i[1:0] + 2) : i[2:0];
      acc(1, 8'h64, {5'h0, i[2:0]});
      acc(1, 8'h65, {1'b0, i[3], i[1:0], 1'b0, m});
      settle;
      chk("pll_a", pll_a_khz, mk[m]);
      chk("fb", pll_a_analog_fb, m == 1);
      chk("bad", main_rate_bad, m > 5);
      chk("b_main", pll_b_from_main, i[3]);
      chk("aux", aux_fwd_khz, i[3] ? 19'h0 : ak[i[2:0]]);
      chk("squelch", aux_squelch, i[3:0] == 0);
      chk("pll_b", pll_b_khz, i[3] ? mk[m] : bk[i[2:0]]);
    end
    for (int c = 15; c >= 0; c--) begin
      acc(1, 8'h61, 8'(c));
      acc(1, 8'h62, 8'(c << 4));
      if (c < 15) chk("hold", cmos_src, oexp(c + 1, 0) >> 7);
      tick;
      chk("c_src", cmos_src, oexp(c, 0) >> 7);
      chk("d_src", diff_src, oexp(c, 1) >> 7);
      chk("c_tap", cmos_tap_ok, c != 0);
      chk("d_tap", diff_tap_ok, c != 0);
      if (c > 4) chk("c_div", cmos_div, oexp(c, 0) & 7'h7f);
      if (c == 3 || c > 4) chk("d_div", diff_div, oexp(c, 1) & 7'h7f);
    end
    for (int b = 0; b < 2; b++) begin
      acc(1, 8'h7a, {b[0], 7'h0a});
      acc(1, 8'h61, 8'h02);
      acc(1, 8'h62, 8'h10);
      tick;
      for (int i = 0; i < 20; i++) begin
        @(posedge clk_sys) #1;
        if (i > 2) begin
          chk("fsync", frame_sync_out, !p2[3]);
          chk("mfsync", multiframe_sync_out, !p2[2]);
          chk("c_low", cmos_lowrate_out, !p2[b ? 1 : 3]);
          chk("d_low", diff_lowrate_out, !p2[b ? 0 : 2]);
        end
        p2 = p1;
        p1 = $random(seed);
        {ref8k_main, ref2k_main, ref8k_aux, ref2k_aux} = p1;
      end
    end
    // Refs low: an enabled inverted sync would sit high
    {ref8k_main, ref2k_main, ref8k_aux, ref2k_aux} = 4'h0;
    acc(1, 8'h63, 8'h80);
    settle;
    chk("fs_on", frame_sync_out, 1);
    chk("mfs_off", multiframe_sync_out, 0);
    // Pulse style needs a fast single-ended rate
    acc(1, 8'h61, 8'h0a);
    acc(1, 8'h7a, 8'h05);
    ref8k_main = 1;
    tick;
    chk("pulse", frame_sync_out, 1);
    tick;
    chk("pulse_end", frame_sync_out, 0);
    foreach (sv[i]) begin
      @(posedge clk_sys) #1 st(sv[i]);
      @(posedge clk_sys) #1 st(0);
      chk("state", op_state, se[i]);
    end
    acc(1, 8'h4d, 8'h0b);
    settle;
    chk("forced", op_state, 3);
    chk("fmode", forced_mode, 1);
    acc(0, 8'h09, 0);
    chk("st_reg", reg_rdata, 8'h03);
    acc(1, 8'h4d, 8'h00);
    @(posedge clk_sys) #1 st(6'h04);
    @(posedge clk_sys) #1 st(0);
    chk("auto", op_state, 4);
    give_verdict;
  end
  initial begin
    #200000;
    error_cnt++;
    give_verdict;
  end
endmodule : tb
